// *** lpct_defs.svh ***
// offsets, field positions, reset values and interval counts of the block
`ifndef LPCT_DEFS_SVH
`define LPCT_DEFS_SVH

`define LPCT_OFF_TRIG_SRC 8'h6B
`define LPCT_OFF_SOFT_TRIG 8'h6C
`define LPCT_OFF_SCHEDULE 8'h6E
`define LPCT_OFF_STATUS 8'h6F
`define LPCT_OFF_GAIN 8'h7A
`define LPCT_OFF_REFERENCE 8'h7C
`define LPCT_OFF_TERM_FIRST 8'h7E
`define LPCT_OFF_TERM_SECOND 8'h7F
`define LPCT_OFF_TERM_THIRD 8'h80

`define LPCT_IDLE_MSB 7
`define LPCT_IDLE_LSB 5
`define LPCT_SETTLE_MSB 4
`define LPCT_SETTLE_LSB 3
`define LPCT_TRIG_PACED_BIT 1
`define LPCT_ENABLE_BIT 0
`define LPCT_SRC_SEL_BIT 0
`define LPCT_SOFT_TRIG_BIT 0

`define LPCT_IDLE_RST 3'h4
`define LPCT_SETTLE_RST 2'h1
`define LPCT_TRIG_PACED_RST 1'h0
`define LPCT_ENABLE_RST 1'h0
`define LPCT_SRC_SEL_RST 1'h0
`define LPCT_SOFT_TRIG_RST 1'h1
`define LPCT_TRIM_RST 8'h00
`define LPCT_REFERENCE_MASK 8'h0F

// interval lengths in converter clock periods
`define LPCT_SLEEP_T0 41'h000_0000_0480
`define LPCT_SLEEP_T1 41'h000_0040_0080
`define LPCT_SLEEP_T2 41'h000_0200_0080
`define LPCT_SLEEP_T3 41'h000_1000_0080
`define LPCT_SLEEP_T4 41'h000_8000_0080
`define LPCT_SLEEP_T5 41'h004_0000_0080
`define LPCT_SLEEP_T6 41'h020_0000_0080
`define LPCT_SLEEP_T7 41'h100_0000_0080
`define LPCT_SETTLE_T0 41'h000_0000_0480
`define LPCT_SETTLE_T1 41'h000_0200_0080
`define LPCT_SETTLE_T2 41'h000_1000_0080
`define LPCT_SETTLE_T3 41'h000_8000_0080

// clk is the converter clock: one cycle per converter clock period
`define LPCT_CYC_PER_CONV 41'h000_0000_0001
`define LPCT_CNT(t) ((t) * `LPCT_CYC_PER_CONV)

`endif

// *** lpct_pkg.sv ***
// types of the low-power calibration scheduler and trim bank
package lpct_pkg;

  localparam int LPCT_CNT_W = 41;

  typedef logic [LPCT_CNT_W-1:0] lpct_count_t;
  typedef logic [7:0] lpct_byte_t;

  typedef enum logic [2:0] {
    LPCT_ST_OFF = 3'b000,
    LPCT_ST_SLEEP = 3'b001,
    LPCT_ST_SETTLE = 3'b010,
    LPCT_ST_CAL = 3'b011,
    LPCT_ST_RETURN = 3'b100
  } lpct_state_t;

endpackage : lpct_pkg

// *** lpct_cal_timer.sv ***
// down counter that times the sleep and settling intervals
module lpct_cal_timer #(
  parameter int W = 41
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // control
  input wire logic load,
  input wire logic [W-1:0] loadValue,
  // status
  output logic done
);

  logic [W-1:0] cnt_r;
  logic busy_r;
  logic cntZero;

  assign cntZero = (cnt_r == '0);
  // done is high in the last of the loadValue cycles after a load edge,
  // so a state that leaves on done lasts exactly loadValue cycles
  assign done = ~busy_r | cntZero;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
    end else if (ce) begin
      if (load) begin
        cnt_r <= loadValue - W'(1);
        busy_r <= 1'b1;
      end else if (busy_r && cntZero) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        cnt_r <= cnt_r - W'(1);
      end
    end
  end

endmodule : lpct_cal_timer

// *** lpct_trim_bank.sv ***
// factory-preloaded trim registers, one entry per trim
module lpct_trim_bank #(
  parameter int ENTRIES = 5,
  parameter int W = 8,
  parameter int IW = 3,
  parameter logic [ENTRIES*W-1:0] MASKS = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // factory fuse preload
  input wire logic fuseLoad,
  input wire logic [ENTRIES*W-1:0] fuseValues,
  // software write
  input wire logic wrEn,
  input wire logic [IW-1:0] wrIndex,
  input wire logic [W-1:0] wrData,
  // trim values
  output logic [ENTRIES*W-1:0] trims
);

  genvar i;
  generate
    for (i = 0; i < ENTRIES; i++) begin : g_entry
      logic [W-1:0] trim_r;
      logic [W-1:0] mask;
      logic hit;
      assign mask = MASKS[i*W +: W];
      assign hit = wrEn && (wrIndex == IW'(i));
      assign trims[i*W +: W] = trim_r;
      // reserved bits are held at zero by the mask
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          trim_r <= '0;
        end else if (ce) begin
          if (fuseLoad) begin
            trim_r <= fuseValues[i*W +: W] & mask;
          end else if (hit) begin
            trim_r <= wrData & mask;
          end
        end
      end
    end
  endgenerate

endmodule : lpct_trim_bank

// *** lpct_sched_regs.sv ***
// low-power calibration scheduler with its registers and the trim bank
//
// Functional notes
// - autonomous sleep length from 3-bit idle code; codes 0-3 are 1152 to 268435584.
// - idle code resets to 4; codes 4-7 give the four longest sleep lengths.
// - settle after waking for the 2-bit settle code length; resets to code 1.
// - trigger pacing off: sleep length comes only from the idle code.
// - trigger pacing on: sleep while trigger high, wake when it goes low.
// - enable bit 0 resets to 0 and acts only with background calibration on.
// - one 8-bit gain trim drives all cores.
// - 4-bit reference trim in the low nibble, fuse loaded, software adjustable.
// - one 8-bit termination trim per input, fuse loaded, read and write.
// - trigger is the software bit when source select is 0, else the pin.
`include "lpct_defs.svh"

module lpct_sched_regs #(
  parameter int NUM_CORES = 4,
  parameter int CORE_W = 2,
  parameter lpct_pkg::lpct_count_t SLEEP_CNT0 = `LPCT_CNT(`LPCT_SLEEP_T0),
  parameter lpct_pkg::lpct_count_t SLEEP_CNT1 = `LPCT_CNT(`LPCT_SLEEP_T1),
  parameter lpct_pkg::lpct_count_t SLEEP_CNT2 = `LPCT_CNT(`LPCT_SLEEP_T2),
  parameter lpct_pkg::lpct_count_t SLEEP_CNT3 = `LPCT_CNT(`LPCT_SLEEP_T3),
  parameter lpct_pkg::lpct_count_t SLEEP_CNT4 = `LPCT_CNT(`LPCT_SLEEP_T4),
  parameter lpct_pkg::lpct_count_t SLEEP_CNT5 = `LPCT_CNT(`LPCT_SLEEP_T5),
  parameter lpct_pkg::lpct_count_t SLEEP_CNT6 = `LPCT_CNT(`LPCT_SLEEP_T6),
  parameter lpct_pkg::lpct_count_t SLEEP_CNT7 = `LPCT_CNT(`LPCT_SLEEP_T7),
  parameter lpct_pkg::lpct_count_t SETTLE_CNT0 = `LPCT_CNT(`LPCT_SETTLE_T0),
  parameter lpct_pkg::lpct_count_t SETTLE_CNT1 = `LPCT_CNT(`LPCT_SETTLE_T1),
  parameter lpct_pkg::lpct_count_t SETTLE_CNT2 = `LPCT_CNT(`LPCT_SETTLE_T2),
  parameter lpct_pkg::lpct_count_t SETTLE_CNT3 = `LPCT_CNT(`LPCT_SETTLE_T3)
) (
  // clock, reset and clock enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // register port
  input wire logic [7:0] regAddr,
  input wire lpct_pkg::lpct_byte_t regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output lpct_pkg::lpct_byte_t regRdData,
  // calibration context
  input wire logic backgroundCalEnable,
  input wire logic calTriggerPin,
  input wire logic calDone,
  // factory fuses
  input wire lpct_pkg::lpct_byte_t fuseGain,
  input wire lpct_pkg::lpct_byte_t fuseReference,
  input wire lpct_pkg::lpct_byte_t fuseTermFirst,
  input wire lpct_pkg::lpct_byte_t fuseTermSecond,
  input wire lpct_pkg::lpct_byte_t fuseTermThird,
  // core scheduling
  output logic coreSleep,
  output logic coreSettling,
  output logic calRequest,
  output logic [CORE_W-1:0] offlineCore,
  // trims
  output lpct_pkg::lpct_byte_t gainTrim,
  output logic [3:0] referenceTrim,
  output lpct_pkg::lpct_byte_t termTrimFirst,
  output lpct_pkg::lpct_byte_t termTrimSecond,
  output lpct_pkg::lpct_byte_t termTrimThird
);
  import lpct_pkg::*;

  localparam int TRIMS = 5;
  localparam int TIW = 3;
  localparam logic [TRIMS*8-1:0] TRIM_MASKS = {
    8'hFF, 8'hFF, 8'hFF, `LPCT_REFERENCE_MASK, 8'hFF
  };

  // schedule register fields
  logic [2:0] idleSel_r;
  logic [1:0] settleSel_r;
  logic trigPaced_r;
  logic lpEnable_r;
  // trigger source fields
  logic srcSel_r;
  logic softTrig_r;
  // read data
  lpct_byte_t rdData_r;
  lpct_byte_t rdData_nxt;
  // pin synchroniser
  logic trigSync1_r;
  logic trigSync2_r;
  // fuse preload
  logic fuseLoaded_r;
  logic fuseLoad;
  // scheduler
  lpct_state_t state_r;
  lpct_state_t state_nxt;
  logic [CORE_W-1:0] core_r;
  logic [CORE_W-1:0] core_nxt;
  logic timerLoad;
  lpct_count_t timerValue;
  logic timerDone;

  // address decode
  logic selTrigSrc;
  logic selSoftTrig;
  logic selSchedule;
  logic selStatus;
  logic selGain;
  logic selReference;
  logic selTermFirst;
  logic selTermSecond;
  logic selTermThird;
  logic selTrim;
  logic [TIW-1:0] trimIndex;
  logic trimWrite;

  assign selTrigSrc = (regAddr == `LPCT_OFF_TRIG_SRC);
  assign selSoftTrig = (regAddr == `LPCT_OFF_SOFT_TRIG);
  assign selSchedule = (regAddr == `LPCT_OFF_SCHEDULE);
  assign selStatus = (regAddr == `LPCT_OFF_STATUS);
  assign selGain = (regAddr == `LPCT_OFF_GAIN);
  assign selReference = (regAddr == `LPCT_OFF_REFERENCE);
  assign selTermFirst = (regAddr == `LPCT_OFF_TERM_FIRST);
  assign selTermSecond = (regAddr == `LPCT_OFF_TERM_SECOND);
  assign selTermThird = (regAddr == `LPCT_OFF_TERM_THIRD);
  assign selTrim = selGain | selReference | selTermFirst | selTermSecond |
                   selTermThird;
  assign trimIndex = selReference ? 3'h1 :
                     selTermFirst ? 3'h2 :
                     selTermSecond ? 3'h3 :
                     selTermThird ? 3'h4 : 3'h0;
  assign trimWrite = regWrStrobe & selTrim;

  // schedule and trigger source registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idleSel_r <= `LPCT_IDLE_RST;
      settleSel_r <= `LPCT_SETTLE_RST;
      trigPaced_r <= `LPCT_TRIG_PACED_RST;
      lpEnable_r <= `LPCT_ENABLE_RST;
    end else if (ce && regWrStrobe && selSchedule) begin
      idleSel_r <= regWrData[`LPCT_IDLE_MSB:`LPCT_IDLE_LSB];
      settleSel_r <= regWrData[`LPCT_SETTLE_MSB:`LPCT_SETTLE_LSB];
      trigPaced_r <= regWrData[`LPCT_TRIG_PACED_BIT];
      lpEnable_r <= regWrData[`LPCT_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      srcSel_r <= `LPCT_SRC_SEL_RST;
      softTrig_r <= `LPCT_SOFT_TRIG_RST;
    end else if (ce && regWrStrobe) begin
      if (selTrigSrc) begin
        srcSel_r <= regWrData[`LPCT_SRC_SEL_BIT];
      end
      if (selSoftTrig) begin
        softTrig_r <= regWrData[`LPCT_SOFT_TRIG_BIT];
      end
    end
  end

  // trigger pin crosses in through two flip-flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trigSync1_r <= 1'b0;
      trigSync2_r <= 1'b0;
    end else if (ce) begin
      trigSync1_r <= calTriggerPin;
      trigSync2_r <= trigSync1_r;
    end
  end

  logic calTrigger;
  assign calTrigger = srcSel_r ? trigSync2_r : softTrig_r;

  // fuses are caught on the first enabled edge after reset release
  assign fuseLoad = ~fuseLoaded_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fuseLoaded_r <= 1'b0;
    end else if (ce) begin
      fuseLoaded_r <= 1'b1;
    end
  end

  logic [TRIMS*8-1:0] trimVec;

  lpct_trim_bank #(
    .ENTRIES(TRIMS),
    .W(8),
    .IW(TIW),
    .MASKS(TRIM_MASKS)
  ) u_trims (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .fuseLoad(fuseLoad),
    .fuseValues({fuseTermThird, fuseTermSecond, fuseTermFirst,
                 fuseReference, fuseGain}),
    .wrEn(trimWrite),
    .wrIndex(trimIndex),
    .wrData(regWrData),
    .trims(trimVec)
  );

  // one gain trim fans out to every core
  assign gainTrim = trimVec[7:0];
  assign referenceTrim = trimVec[11:8];
  assign termTrimFirst = trimVec[23:16];
  assign termTrimSecond = trimVec[31:24];
  assign termTrimThird = trimVec[39:32];

  // read path, data valid only in the cycle after the strobe
  lpct_byte_t schedValue;
  lpct_byte_t statusValue;
  lpct_byte_t trimValue;

  assign schedValue = {idleSel_r, settleSel_r, 1'b0, trigPaced_r, lpEnable_r};
  assign statusValue = {3'h0, (CORE_W)'(core_r) , state_r} & 8'hFF;
  assign trimValue = trimVec[trimIndex*8 +: 8];
  assign rdData_nxt = !regRdStrobe ? 8'h00 :
                      selSchedule ? schedValue :
                      selTrigSrc ? {7'h00, srcSel_r} :
                      selSoftTrig ? {7'h00, softTrig_r} :
                      selStatus ? statusValue :
                      selTrim ? trimValue : 8'h00;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData_r <= 8'h00;
    end else if (ce) begin
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;

  // interval tables
  lpct_count_t sleepTable [8];
  lpct_count_t settleTable [4];
  lpct_count_t sleepCount;
  lpct_count_t settleCount;

  assign sleepTable[0] = SLEEP_CNT0;
  assign sleepTable[1] = SLEEP_CNT1;
  assign sleepTable[2] = SLEEP_CNT2;
  assign sleepTable[3] = SLEEP_CNT3;
  assign sleepTable[4] = SLEEP_CNT4;
  assign sleepTable[5] = SLEEP_CNT5;
  assign sleepTable[6] = SLEEP_CNT6;
  assign sleepTable[7] = SLEEP_CNT7;
  assign settleTable[0] = SETTLE_CNT0;
  assign settleTable[1] = SETTLE_CNT1;
  assign settleTable[2] = SETTLE_CNT2;
  assign settleTable[3] = SETTLE_CNT3;
  assign sleepCount = sleepTable[idleSel_r];
  assign settleCount = settleTable[settleSel_r];

  // scheduler
  logic lpActive;
  logic wakeNow;
  logic lastCore;

  assign lpActive = lpEnable_r & backgroundCalEnable;
  // pacing picks the wake condition; the idle timer is ignored when paced
  assign wakeNow = trigPaced_r ? ~calTrigger : timerDone;
  assign lastCore = (core_r == CORE_W'(NUM_CORES - 1));

  always_comb begin
    state_nxt = state_r;
    core_nxt = core_r;
    timerLoad = 1'b0;
    timerValue = sleepCount;
    case (state_r)
      LPCT_ST_OFF: begin
        if (lpActive) begin
          state_nxt = LPCT_ST_SLEEP;
          timerLoad = 1'b1;
        end
      end
      LPCT_ST_SLEEP: begin
        if (!lpActive) begin
          state_nxt = LPCT_ST_OFF;
        end else if (wakeNow) begin
          state_nxt = LPCT_ST_SETTLE;
          timerLoad = 1'b1;
          timerValue = settleCount;
        end
      end
      LPCT_ST_SETTLE: begin
        if (!lpActive) begin
          state_nxt = LPCT_ST_OFF;
        end else if (timerDone) begin
          state_nxt = LPCT_ST_CAL;
        end
      end
      LPCT_ST_CAL: begin
        if (!lpActive) begin
          state_nxt = LPCT_ST_OFF;
        end else if (calDone) begin
          state_nxt = LPCT_ST_RETURN;
        end
      end
      LPCT_ST_RETURN: begin
        // core goes back to service and the next one is taken offline
        core_nxt = lastCore ? '0 : core_r + CORE_W'(1);
        if (!lpActive) begin
          state_nxt = LPCT_ST_OFF;
        end else begin
          state_nxt = LPCT_ST_SLEEP;
          timerLoad = 1'b1;
        end
      end
      default: begin
        state_nxt = LPCT_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= LPCT_ST_OFF;
      core_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      core_r <= core_nxt;
    end
  end

  lpct_cal_timer #(
    .W(LPCT_CNT_W)
  ) u_timer (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .load(timerLoad),
    .loadValue(timerValue),
    .done(timerDone)
  );

  assign coreSleep = (state_r == LPCT_ST_SLEEP);
  assign coreSettling = (state_r == LPCT_ST_SETTLE);
  assign calRequest = (state_r == LPCT_ST_CAL);
  assign offlineCore = core_r;

endmodule : lpct_sched_regs

// *** lpct_sched_regs_checker.sv ***
// assertion checker for the calibration scheduler and trims
module lpct_sched_regs_checker #(
  parameter int CORE_W = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // register port
  input wire logic [7:0] regAddr,
  input wire lpct_pkg::lpct_byte_t regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  input wire lpct_pkg::lpct_byte_t regRdData,
  // scheduling
  input wire logic backgroundCalEnable,
  input wire logic calDone,
  input wire logic coreSleep,
  input wire logic coreSettling,
  input wire logic calRequest,
  input wire logic [CORE_W-1:0] offlineCore,
  // trims
  input wire lpct_pkg::lpct_byte_t gainTrim,
  input wire logic [3:0] referenceTrim,
  input wire lpct_pkg::lpct_byte_t termTrimFirst
);
  timeunit 1ns;
  timeprecision 1ps;
  import lpct_pkg::*;
  // the scheduler's last decision saw background on and no fresh write
  logic stayOn_r;
  logic wrSeen_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stayOn_r <= 1'b0;
      wrSeen_r <= 1'b0;
    end else if (ce) begin
      stayOn_r <= backgroundCalEnable && !wrSeen_r;
      wrSeen_r <= regWrStrobe;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn || !ce);
  sequence s_ret;
    !calRequest && !coreSleep ##1 (coreSleep || !stayOn_r);
  endsequence
  sequence s_wait;
    calRequest && !calDone ##1 stayOn_r;
  endsequence
  property p_excl;
    $onehot0({coreSleep, coreSettling, calRequest});
  endproperty
  property p_gain_rd;
    regRdStrobe && regAddr == 8'h7A |=> regRdData == $past(gainTrim);
  endproperty
  property p_ref_rd;
    regRdStrobe && regAddr == 8'h7C |=>
      regRdData == {4'h0, $past(referenceTrim)};
  endproperty
  property p_ref_wr;
    regWrStrobe && regAddr == 8'h7C |=>
      {4'h0, referenceTrim} == ($past(regWrData) & 8'h0F);
  endproperty
  property p_term_wr;
    regWrStrobe && regAddr == 8'h7E |=> termTrimFirst == $past(regWrData);
  endproperty
  property p_settle;
    $fell(coreSleep) && stayOn_r |-> coreSettling;
  endproperty
  property p_cal;
    $fell(coreSettling) && stayOn_r |-> calRequest;
  endproperty
  property p_hold;
    s_wait |-> calRequest;
  endproperty
  property p_ret;
    calRequest && calDone && backgroundCalEnable && !wrSeen_r |=> s_ret;
  endproperty
  property p_idx;
    $rose(coreSleep) && $past(calRequest, 2) |->
      offlineCore == CORE_W'($past(offlineCore) + 1'b1);
  endproperty
  property p_off;
    !backgroundCalEnable |=> !coreSleep && !coreSettling && !calRequest;
  endproperty
  a_excl: assert property (p_excl) else $error("scheduler states overlap");
  a_gain_rd: assert property (p_gain_rd) else $error("gain read wrong");
  a_ref_rd: assert property (p_ref_rd) else $error("reference read wrong");
  a_ref_wr: assert property (p_ref_wr) else $error("reference write lost");
  a_term_wr: assert property (p_term_wr) else $error("term write lost");
  a_settle: assert property (p_settle) else $error("no settle after sleep");
  a_cal: assert property (p_cal) else $error("no calibration after settle");
  a_hold: assert property (p_hold) else $error("request dropped early");
  a_ret: assert property (p_ret) else $error("no return to sleep");
  a_idx: assert property (p_idx) else $error("offline core not advanced");
  a_off: assert property (p_off) else $error("runs without background");
endmodule : lpct_sched_regs_checker

bind lpct_sched_regs lpct_sched_regs_checker #(.CORE_W(CORE_W)) u_chk (
  .clk(clk), .rstn(rstn), .ce(ce), .regAddr(regAddr),
  .regWrData(regWrData), .regWrStrobe(regWrStrobe),
  .regRdStrobe(regRdStrobe), .regRdData(regRdData),
  .backgroundCalEnable(backgroundCalEnable), .calDone(calDone),
  .coreSleep(coreSleep), .coreSettling(coreSettling),
  .calRequest(calRequest), .offlineCore(offlineCore),
  .gainTrim(gainTrim), .referenceTrim(referenceTrim),
  .termTrimFirst(termTrimFirst)
);

// *** test_lpct_sched_regs.sv ***
// self-checking bench for the calibration scheduler and trims
module test_lpct_sched_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import lpct_pkg::*;
  // shortened sleep and settle counts of code 0; each code adds one
  localparam int SB = 2;
  localparam int TB = 3;
  localparam lpct_byte_t FG = 8'h3C;
  localparam lpct_byte_t FR = 8'hA5;
  localparam lpct_byte_t F1 = 8'h5A;
  localparam lpct_byte_t F2 = 8'hC3;
  localparam lpct_byte_t F3 = 8'h96;
  logic clk, rstn, ce, regWrStrobe, regRdStrobe, bgCal, trigPin, calDone;
  logic [7:0] regAddr;
  lpct_byte_t regWrData, regRdData, gainT, term1, term2, term3;
  logic coreSleep, coreSettling, calRequest;
  logic [1:0] offlineCore;
  logic [3:0] refT;
  int error_cnt, tests_run, cycles, n;

  lpct_sched_regs #(
    .SLEEP_CNT0(SB), .SLEEP_CNT1(SB+1), .SLEEP_CNT2(SB+2),
    .SLEEP_CNT3(SB+3), .SLEEP_CNT4(SB+4), .SLEEP_CNT5(SB+5),
    .SLEEP_CNT6(SB+6), .SLEEP_CNT7(SB+7), .SETTLE_CNT0(TB),
    .SETTLE_CNT1(TB+1), .SETTLE_CNT2(TB+2), .SETTLE_CNT3(TB+3)
  ) u_dut (
    .clk(clk), .rstn(rstn), .ce(ce), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .backgroundCalEnable(bgCal), .calTriggerPin(trigPin),
    .calDone(calDone), .fuseGain(FG), .fuseReference(FR),
    .fuseTermFirst(F1), .fuseTermSecond(F2), .fuseTermThird(F3),
    .coreSleep(coreSleep), .coreSettling(coreSettling),
    .calRequest(calRequest), .offlineCore(offlineCore),
    .gainTrim(gainT), .referenceTrim(refT), .termTrimFirst(term1),
    .termTrimSecond(term2), .termTrimThird(term3)
  );

  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input lpct_byte_t d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge clk);
    regWrStrobe <= 1'b0;
    #1;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input lpct_byte_t e);
    @(posedge clk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge clk);
    regRdStrobe <= 1'b0;
    #1;
    chk($sformatf("read %h", a), regRdData, e);
  endtask : rdchk

  // length in cycles of the sleep (sel 0) or settle (sel 1) state
  task automatic span(input bit sel);
    n = 0;
    while ((sel ? coreSettling : coreSleep) === 1'b1 && n < 60) begin
      n++;
      cyc(1);
    end
  endtask : span

  task automatic t_reset;
    rdchk(8'h6E, 8'h88);
    rdchk(8'h6B, 8'h00);
    rdchk(8'h6C, 8'h01);
    rdchk(8'h7A, FG);
    rdchk(8'h7C, FR & 8'h0F);
    rdchk(8'h7E, F1);
    rdchk(8'h7F, F2);
    rdchk(8'h80, F3);
    rdchk(8'h10, 8'h00);
    rdchk(8'h6F, 8'h00);
  endtask : t_reset

  task automatic t_trims;
    wr(8'h7A, 8'h5B);
    wr(8'h7C, 8'h06);
    wr(8'h7E, 8'h11);
    wr(8'h7F, 8'h22);
    wr(8'h80, 8'h33);
    chk("gainTrim", gainT, 8'h5B);
    chk("referenceTrim", {4'h0, refT}, 8'h06);
    chk("termTrimSecond", term2, 8'h22);
    chk("termTrimThird", term3, 8'h33);
    rdchk(8'h7C, 8'h06);
    rdchk(8'h7E, 8'h11);
    rdchk(8'h80, 8'h33);
    ce <= 1'b0;
    wr(8'h7A, 8'hAA);
    ce <= 1'b1;
    rdchk(8'h7A, 8'h5B);
  endtask : t_trims

  task automatic t_auto;
    wr(8'h6E, 8'h89);
    cyc(5);
    chk("sleep without background", coreSleep, 1'b0);
    wr(8'h6E, 8'h00);
    bgCal <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      wr(8'h6E, {k[2:0], k[1:0], 3'b001});
      n = 0;
      while (coreSleep !== 1'b1 && n < 70) begin
        n++;
        cyc(1);
      end
      span(0);
      chk("sleep cycles", 8'(n), 8'(SB + k));
      span(1);
      chk("settle cycles", 8'(n), 8'(TB + k % 4));
      cyc(3);
      chk("request held", calRequest, 1'b1);
      @(posedge clk);
      calDone <= 1'b1;
      cyc(1);
      calDone <= 1'b0;
      chk("return cycle", {calRequest, coreSleep}, 8'h00);
      cyc(1);
      chk("sleep again", coreSleep, 1'b1);
      chk("offline core", offlineCore, 8'((k + 1) % 4));
      wr(8'h6E, 8'h00);
      cyc(1);
      chk("disabled", {coreSleep, coreSettling, calRequest}, 8'h00);
    end
  endtask : t_auto

  task automatic t_paced;
    wr(8'h6C, 8'h01);
    wr(8'h6E, 8'hEB);
    cyc(20);
    chk("paced sleep", coreSleep, 1'b1);
    rdchk(8'h6F, 8'h01);
    wr(8'h6C, 8'h00);
    cyc(2);
    chk("soft wake", coreSettling, 1'b1);
    wr(8'h6E, 8'h00);
    wr(8'h6B, 8'h01);
    wr(8'h6E, 8'hEB);
    cyc(20);
    chk("pin sleep", coreSleep, 1'b1);
    trigPin <= 1'b0;
    cyc(4);
    chk("pin wake", coreSettling, 1'b1);
    bgCal <= 1'b0;
    cyc(2);
    chk("aborted", {coreSleep, coreSettling, calRequest}, 8'h00);
  endtask : t_paced

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test;
    end
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrStrobe = 1'b0;
    regRdStrobe = 1'b0;
    bgCal = 1'b0;
    trigPin = 1'b1;
    calDone = 1'b0;
    repeat (12) @(posedge clk);
    chk("trim in reset", gainT | term1, 8'h00);
    rstn <= 1'b1;
    cyc(2);
    t_reset;
    t_trims;
    t_auto;
    t_paced;
    end_of_test;
  end
endmodule : test_lpct_sched_regs
